// ### core/aomc_pkg.sv
// Contract
// - Mode register at 0x01, 16 bits, resets 0x2000
// - Any write restarts filter, clears ready, converts except in standby or power-down
// - Bit 15 enables reference and buffered output
// - Bit 13 gives settled-rate output only
// - Bits 10:8 choose post-switch settling wait
// - Bits 6:4 choose conversion or calibration mode
// - Bits 3:2 choose the master clock source
// - Internal clock choice also powers the oscillator
package aomc_pkg;

  // Register address and geometry
  localparam logic [7:0]  AOMC_MODE_ADDR   = 8'h01;
  localparam int          AOMC_REG_W       = 16;
  localparam logic [15:0] AOMC_MODE_RESET  = 16'h2000;
  // Writable bit mask: 15,14,13,10:8,6:4,3:2
  localparam logic [15:0] AOMC_MODE_WMASK  = 16'he77c;

  // Field positions
  localparam int AOMC_REF_EN_BIT  = 15;
  localparam int AOMC_SETTLED_BIT = 13;
  localparam int AOMC_DELAY_LSB   = 8;
  localparam int AOMC_MODE_LSB    = 4;
  localparam int AOMC_CLK_LSB     = 2;

  // Clock rate
  localparam int AOMC_CLK_MHZ = 200;

  // Settling waits in microseconds, per delay code
  localparam int AOMC_DLY_US_1 = 32;
  localparam int AOMC_DLY_US_2 = 128;
  localparam int AOMC_DLY_US_3 = 320;
  localparam int AOMC_DLY_US_4 = 800;
  localparam int AOMC_DLY_US_5 = 1600;
  localparam int AOMC_DLY_US_6 = 4000;
  localparam int AOMC_DLY_US_7 = 8000;

  // Operating modes
  typedef enum logic [2:0] {
    AOMC_CONT     = 3'h0,
    AOMC_SINGLE   = 3'h1,
    AOMC_STANDBY  = 3'h2,
    AOMC_PWRDN    = 3'h3,
    AOMC_INT_OFS  = 3'h4,
    AOMC_INT_GAIN = 3'h5,
    AOMC_SYS_OFS  = 3'h6,
    AOMC_SYS_GAIN = 3'h7
  } aomc_mode_t;

  // Master clock sources
  typedef enum logic [1:0] {
    AOMC_CLK_INT     = 2'h0,
    AOMC_CLK_INT_OUT = 2'h1,
    AOMC_CLK_EXT     = 2'h2,
    AOMC_CLK_XTAL    = 2'h3
  } aomc_clk_t;

  // Decoded configuration handed to the converter core
  typedef struct packed {
    logic       ref_enable;
    logic       settled_only_output;
    logic [2:0] delay_code;
    aomc_mode_t mode;
    aomc_clk_t  master_clock_source;
  } aomc_cfg_t;

  // Clock-routing controls
  typedef struct packed {
    logic osc_enable;
    logic clock_io_out_en;
    logic clock_io_in_sel;
    logic crystal_en;
  } aomc_clkctl_t;

endpackage

// ### core/aomc_settle_timer.sv
`timescale 1ns/10ps
// Waits the programmed settling time after a channel switch
module aomc_settle_timer
  import aomc_pkg::*;
#(
  parameter int CNT_W = 21
)(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       start,       // Channel switch or restart
  input  wire logic [2:0] delay_code,
  output logic            busy
);

  // Cycles per delay code, derived from the rate
  function automatic logic [CNT_W-1:0] cycles(input logic [2:0] code);
    int us;
    us = 0;
    case (code)
      3'h1:    us = AOMC_DLY_US_1;
      3'h2:    us = AOMC_DLY_US_2;
      3'h3:    us = AOMC_DLY_US_3;
      3'h4:    us = AOMC_DLY_US_4;
      3'h5:    us = AOMC_DLY_US_5;
      3'h6:    us = AOMC_DLY_US_6;
      3'h7:    us = AOMC_DLY_US_7;
      default: us = 0;
    endcase
    return CNT_W'(us * AOMC_CLK_MHZ);
  endfunction

  logic [CNT_W-1:0] count;       // Cycles left to wait
  logic [CNT_W-1:0] next_count;

  // Load on start, then count down to zero
  always_comb
  begin
    next_count = count;
    if (start)
      next_count = cycles(delay_code);
    else if (count != '0)
      next_count = count - CNT_W'(1);
  end

  // Register the count
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= '0;
    else
      count <= next_count;
  end

  // Code 000 gives no wait at all
  assign busy = (count != '0);

endmodule // aomc_settle_timer

// ### core/aomc_mode_ctrl.sv
`timescale 1ns/10ps
// Operating-mode register and its side effects
module aomc_mode_ctrl
  import aomc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        reg_wr,          // Register write strobe
  input  wire logic        reg_rd,          // Register read strobe
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]      reg_rdata,
  input  wire logic        channel_switch,  // Pulse from sequencer
  input  wire logic        conv_done,       // Pulse from filter path
  output aomc_cfg_t        cfg,
  output aomc_clkctl_t     clkctl,
  output logic             reference_output_pin_en,
  output logic             filter_reset,    // One-cycle pulse
  output logic             start_conv,      // One-cycle pulse
  output logic             data_ready_n,    // Low while a result waits
  output logic             input_hold       // High during settling wait
);

  logic [15:0]  mode_reg;       // Stored register
  logic [15:0]  next_mode_reg;
  logic [15:0]  next_rdata;
  logic         restart;        // Restart pulse
  logic         next_restart;
  logic         ready_n;
  logic         next_ready_n;
  aomc_clk_t    clk_sel;
  logic         hit;            // Address matches
  logic         wr_hit;         // Write taken by this register

  assign hit    = (reg_addr == AOMC_MODE_ADDR);
  // Side effects key off the write itself so they land one edge after it
  assign wr_hit = reg_wr && hit;

  // Write path; read-only reserved bits never store
  always_comb
  begin
    next_mode_reg = mode_reg;
    next_restart  = 1'b0;
    if (reg_wr && hit)
    begin
      // Reserved bits are masked to zero here
      next_mode_reg = reg_wdata & AOMC_MODE_WMASK;
      next_restart  = 1'b1;
    end
  end

  // Register storage
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg <= AOMC_MODE_RESET;
      restart  <= 1'b0;
    end
    else
    begin
      mode_reg <= next_mode_reg;
      restart  <= next_restart;
    end
  end

  // Readback; unmapped addresses return zero
  always_comb
  begin
    next_rdata = reg_rdata;
    if (reg_rd)
      next_rdata = hit ? mode_reg : 16'h0000;
  end

  // Data-ready indicator: a write clears it over a completion
  always_comb
  begin
    next_ready_n = ready_n;
    if (wr_hit)
      next_ready_n = 1'b1;
    else if (conv_done)
      next_ready_n = 1'b0;
  end

  // Read data and ready registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 16'h0000;
      ready_n   <= 1'b1;
    end
    else
    begin
      reg_rdata <= next_rdata;
      ready_n   <= next_ready_n;
    end
  end

  // Field decode
  assign cfg.ref_enable          = mode_reg[AOMC_REF_EN_BIT];
  assign cfg.settled_only_output = mode_reg[AOMC_SETTLED_BIT];
  assign cfg.delay_code          = mode_reg[AOMC_DELAY_LSB +: 3];
  assign cfg.mode                = aomc_mode_t'(mode_reg[AOMC_MODE_LSB +: 3]);
  assign clk_sel                 = aomc_clk_t'(mode_reg[AOMC_CLK_LSB +: 2]);
  assign cfg.master_clock_source = clk_sel;

  // Clock routing; internal choices also power the oscillator
  assign clkctl.osc_enable      = (clk_sel == AOMC_CLK_INT)
                                || (clk_sel == AOMC_CLK_INT_OUT);
  assign clkctl.clock_io_out_en = (clk_sel == AOMC_CLK_INT_OUT);
  assign clkctl.clock_io_in_sel = (clk_sel == AOMC_CLK_EXT);
  assign clkctl.crystal_en      = (clk_sel == AOMC_CLK_XTAL);

  assign reference_output_pin_en = mode_reg[AOMC_REF_EN_BIT];
  assign filter_reset            = restart;
  // Standby and power-down launch no conversion
  assign start_conv   = restart && (cfg.mode != AOMC_STANDBY)
                        && (cfg.mode != AOMC_PWRDN);
  assign data_ready_n = ready_n;

  // Settling wait after a switch or a write; the code being written is
  // used so that the new delay applies to the restart it causes
  aomc_settle_timer u_settle (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .start      (channel_switch || wr_hit),
    .delay_code (next_mode_reg[AOMC_DELAY_LSB +: 3]),
    .busy       (input_hold)
  );

endmodule // aomc_mode_ctrl

// ### test/aomc_mode_ctrl_properties.sv
`timescale 1ns/10ps
// Watches the mode register's side effects at the ports
module aomc_mode_ctrl_properties
  import aomc_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire aomc_cfg_t   cfg,
  input wire aomc_clkctl_t clkctl,
  input wire logic        reference_output_pin_en,
  input wire logic        filter_reset,
  input wire logic        start_conv,
  input wire logic        data_ready_n,
  input wire logic        input_hold
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // A write that reaches this register
  wire w = reg_wr && reg_addr == 8'h01;
  a_write_restart: assert property (w |=> filter_reset && data_ready_n)
    else $error("write did not restart");
  a_start_conv: assert property (w && reg_wdata[6:5] != 2'h1 |=> start_conv)
    else $error("no conversion start");
  a_cfg_load: assert property (w |=> cfg == {$past(reg_wdata[15]), $past(reg_wdata[13]),
    $past(reg_wdata[10:8]), $past(reg_wdata[6:2])})
    else $error("config not loaded");
  a_clk_route: assert property (clkctl.clock_io_out_en == (cfg.master_clock_source == 2'h1)
    && clkctl.clock_io_in_sel == (cfg.master_clock_source == 2'h2)
    && clkctl.crystal_en == (cfg.master_clock_source == 2'h3))
    else $error("clock routing mismatch");
  a_ref_pin: assert property (reference_output_pin_en == cfg.ref_enable)
    else $error("reference pin mismatch");
  a_osc_on: assert property (!cfg.master_clock_source[1] |-> clkctl.osc_enable)
    else $error("oscillator off");
  a_rsvd_zero: assert property (reg_rd |=> (reg_rdata & 16'h1883) == 16'h0000)
    else $error("reserved bits set");
  a_unmapped_read: assert property (reg_rd && reg_addr != 8'h01 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_reset_value: assert property ($rose(rst_n) |-> cfg == 10'h100)
    else $error("wrong reset config");
  a_hold_start: assert property (w && reg_wdata[10:8] != 3'h0 |=> input_hold)
    else $error("settle wait not begun");
  c_start: cover property (w ##1 start_conv);
  c_hold_end: cover property (input_hold ##1 !input_hold);
  c_unmapped: cover property (reg_rd && reg_addr != 8'h01);
endmodule // aomc_mode_ctrl_properties

bind aomc_mode_ctrl aomc_mode_ctrl_properties u_aomc_mode_ctrl_properties (
  .core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cfg(cfg),
  .clkctl(clkctl), .reference_output_pin_en(reference_output_pin_en),
  .filter_reset(filter_reset), .start_conv(start_conv),
  .data_ready_n(data_ready_n), .input_hold(input_hold));

// ### test/adc_operating_mode_control_tb.sv
`timescale 1ns/10ps
module adc_operating_mode_control_tb
  import aomc_pkg::*;
;
  logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, channel_switch = 0, conv_done = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, e;
  aomc_cfg_t cfg;
  aomc_clkctl_t clkctl;
  logic ref_en, filter_reset, start_conv, data_ready_n, input_hold;
  int n_mismatch = 0, n_compared = 0;
  // Written value beside the value it must read back as
  logic [31:0] rows [9] = '{32'hffff_e77c, 32'h0804_0004, 32'h2190_2110, 32'h4028_4028,
    32'h8033_8030, 32'h1247_0244, 32'h0358_0358, 32'h0064_0064, 32'h007c_007c};
  always #2.5 core_clk = ~core_clk;
  aomc_mode_ctrl u_aomc_mode_ctrl (.core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .channel_switch(channel_switch), .conv_done(conv_done), .cfg(cfg), .clkctl(clkctl),
    .reference_output_pin_en(ref_en), .filter_reset(filter_reset),
    .start_conv(start_conv), .data_ready_n(data_ready_n), .input_hold(input_hold));
  task automatic chk(input logic [15:0] s, input logic [15:0] x);
    n_compared++;
    if (s !== x)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, x);
    end
  endtask
  // One-cycle strobes; results settle one edge later
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
  endtask
  // One-cycle pulse: sel high gives a completion, low a channel switch
  task automatic pulse(input bit sel);
    @(posedge core_clk);
    if (sel)
      conv_done <= 1'b1;
    else
      channel_switch <= 1'b1;
    @(posedge core_clk);
    conv_done <= 1'b0;
    channel_switch <= 1'b0;
    #1;
  endtask
  task automatic print_verdict;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Cuts a hang short; the tests need about 6500 cycles
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    print_verdict;
  end
  initial
  begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      e = rows[i][15:0];
      wr(8'h01, rows[i][31:16]);
      chk(filter_reset, 16'h1);
      chk(start_conv, e[6:5] != 2'h1);
      chk(data_ready_n, 16'h1);
      rd(8'h01);
      chk(reg_rdata, e);
      chk(cfg, {e[15], e[13], e[10:8], e[6:2]});
      chk(clkctl.osc_enable, !e[3]);
      chk(ref_en, e[15]);
    end
    // Mid-run reset brings back the documented value
    @(posedge core_clk);
    rst_n <= 1'b0;
    @(posedge core_clk);
    rst_n <= 1'b1;
    rd(8'h01);
    chk(reg_rdata, 16'h2000);
    // Other addresses neither restart nor store
    wr(8'h02, 16'hffff);
    chk(filter_reset, 16'h0);
    rd(8'h02);
    chk(reg_rdata, 16'h0000);
    // 32 us wait is 6400 cycles at 200 MHz
    wr(8'h01, 16'h0100);
    pulse(1'b0);
    repeat (6390) @(posedge core_clk);
    #1;
    chk(input_hold, 16'h1);
    repeat (20) @(posedge core_clk);
    #1;
    chk(input_hold, 16'h0);
    pulse(1'b1);
    chk(data_ready_n, 16'h0);
    wr(8'h01, 16'h0000);
    chk(data_ready_n, 16'h1);
    print_verdict;
  end
endmodule // adc_operating_mode_control_tb
